// [sim/dscr_mcu_model.sv]
`timescale 1ns/10ps
// ----------
// Bus master
// ----------
// Open-drain pins; the clock stands still between frames
module dscr_mcu_model (
  input wire scl_w,
  input wire sda_w,
  output reg scl_low,
  output reg sda_low,
  output reg cs
);
  localparam int HP = 80;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    cs = 1'b0;
  end
  // Pins move on clock edges, so they change by non-blocking assignment
  task automatic cs_set(input logic v);
    #HP cs <= v;
    #HP;
  endtask
  // LSB first, each bit placed at the falling edge
  task automatic tw_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      #HP scl_low <= 1'b1;
      sda_low <= !b[i];
      #HP scl_low <= 1'b0;
    end
    #HP sda_low <= 1'b0;
  endtask
  // Waits out a stretched clock, but only up to 50 us so a hang shows
  task automatic scl_rel();
    int n;
    n = 0;
    #HP scl_low <= 1'b0;
    while (scl_w !== 1'b1 && n < 5000) begin
      #10 n++;
    end
    #HP;
  endtask
  // Data falls while the clock is high
  task automatic start();
    #HP sda_low <= 1'b1;
    #HP scl_low <= 1'b1;
  endtask
  // MSB first; n below 8 breaks off mid-byte, 8 adds the ack clock
  task automatic ibyte(input logic [7:0] b, input int n, output logic ack);
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      #20 sda_low <= !b[i];
      scl_rel();
      scl_low <= 1'b1;
    end
    if (n == 8) begin
      #20 sda_low <= 1'b0;
      scl_rel();
      ack = !sda_w;
      scl_low <= 1'b1;
    end
  endtask
  // Data rises while the clock is high
  task automatic stop();
    #20 sda_low <= 1'b1;
    scl_rel();
    sda_low <= 1'b0;
    #HP;
  endtask
endmodule

// [sim/dscr_rx_assertions.sv]
`timescale 1ns/10ps
// ----------
// Pin checks
// ----------
module dscr_rx_assertions (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire i2c_sel_i,
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe_o,
  input wire sda_o,
  input wire sda_oe_o,
  input wire chip_sel_i,
  input wire line_sync_i,
  input wire frame_sync_i,
  input wire cmd_valid_o,
  input wire [7:0] cmd_data_o,
  input wire cmd_ready_i,
  input wire overrun_o,
  input wire bus_err_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  reg [2:0] low_q;
  wire [2:0] low_d = (line_sync_i && !frame_sync_i) ? 3'h0 : low_q + {2'h0, low_q != 3'h7};
  // Run of cycles with the retrace window shut; covers the synchroniser delay
  always @(posedge core_clk_i) begin
    low_q <= rst_n_i ? low_d : 3'h0;
  end
  sequence tw_mode;
    !i2c_sel_i [*4];
  endsequence
  sequence cs_quiet;
    !chip_sel_i [*4];
  endsequence
  pins_low_a:
    assert property (!scl_o && !sda_o) else $error("pin data not low");
  tw_quiet_a:
    assert property (tw_mode |-> !sda_oe_o && !scl_oe_o) else $error("drive in 3-wire");
  err_pulse_a:
    assert property (bus_err_o |=> !bus_err_o) else $error("error pulse too long");
  stretch_hold_a:
    assert property (scl_oe_o && low_q == 3'h7 && !cmd_valid_o |=> scl_oe_o)
      else $error("stretch ended early");
  stretch_ack_a:
    assert property (scl_oe_o |-> sda_oe_o) else $error("stretch without ack");
  ack_fall_a:
    assert property ($rose(sda_oe_o) |-> !$past(scl_i, 3)) else $error("ack off clock low");
  cmd_hold_a:
    assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_data_o))
      else $error("byte dropped");
  overrun_keep_a:
    assert property (cs_quiet ##0 overrun_o |=> overrun_o) else $error("overrun lost");
endmodule

// [sim/tb_top.sv]
`timescale 1ns/10ps
`include "dscr_map.vh"
`define CHK(a, e) \
  begin \
    compares++; \
    if ((a) !== (e)) begin \
      miscompares++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
// ----------
// Bench top
// ----------
module tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg i2c_sel = 1'b0;
  reg test_mode = 1'b0;
  reg line_sync = 1'b0;
  reg frame_sync = 1'b0;
  reg ram_bank = 1'b0;
  reg cmd_ready = 1'b1;
  wire scl_oe, sda_oe, cmd_valid, overrun, bus_err, scl_low, sda_low, cs;
  wire [7:0] cmd_data;
  wire scl_dat, sda_dat;
  wire scl_w = !(scl_low || scl_oe);
  wire sda_w = !(sda_low || sda_oe);
  int compares = 0;
  int miscompares = 0;
  int unsigned seed = 66036;
  logic [7:0] got[$];
  logic [7:0] exp[$];
  logic err_seen = 1'b0;
  logic str_seen = 1'b0;
  logic ack;
  logic [7:0] b;
  logic [7:0] adr[4] = '{8'hba, 8'hbc, 8'hbb, 8'hbb};
  dscr_rx i_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .i2c_sel_i(i2c_sel), .test_mode_i(test_mode),
    .scl_i(scl_w), .scl_o(scl_dat), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_dat),
    .sda_oe_o(sda_oe), .chip_sel_i(cs), .line_sync_i(line_sync), .frame_sync_i(frame_sync),
    .ram_bank_i(ram_bank),
    .cmd_valid_o(cmd_valid), .cmd_data_o(cmd_data), .cmd_ready_i(cmd_ready),
    .overrun_o(overrun), .bus_err_o(bus_err));
  dscr_mcu_model i_mcu (.scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low),
    .cs(cs));
  initial begin
    forever #5 clk = !clk;
  end
  // Bytes taken by the interpreter, and sticky event flags; read mid-cycle
  always @(negedge clk) begin
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
      got.push_back(cmd_data);
    if (bus_err === 1'b1)
      err_seen = 1'b1;
    if (scl_oe === 1'b1)
      str_seen = 1'b1;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic ack_exp(input logic [7:0] a, input logic tm);
    return a[7:1] == `DSCR_SLV_ADDR && (!a[0] || tm);
  endfunction
  // Bounded wait for the expected bytes, then compare in order
  task automatic settle(input string name);
    logic [7:0] g;
    for (int i = 0; i < 300 && got.size() < exp.size(); i++)
      @(posedge clk);
    repeat (8) @(posedge clk);
    `CHK(got.size(), exp.size())
    while (exp.size() > 0 && got.size() > 0) begin
      g = got.pop_front();
      `CHK(g, exp.pop_front())
    end
    got.delete();
    exp.delete();
    $display("test %s done", name);
  endtask
  task automatic conclude();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well past the expected run of about 90 us
  initial begin
    #400_000;
    miscompares++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    i_mcu.cs_set(1'b1);
    repeat (6) begin
      b = rnd();
      exp.push_back(b);
      i_mcu.tw_bits(b, 8);
    end
    settle("3-wire stream");
    i_mcu.tw_bits(rnd(), 3);
    i_mcu.cs_set(1'b0);
    i_mcu.tw_bits(rnd(), 8);
    i_mcu.cs_set(1'b1);
    b = rnd();
    exp.push_back(b);
    i_mcu.tw_bits(b, 8);
    settle("abort");
    @(posedge clk) cmd_ready <= 1'b0;
    for (int i = 0; i < 34; i++) begin
      b = rnd();
      if (i < 33)
        exp.push_back(b);
      i_mcu.tw_bits(b, 8);
    end
    `CHK(overrun, 1'b1)
    @(posedge clk) cmd_ready <= 1'b1;
    settle("overrun");
    i_mcu.cs_set(1'b0);
    i_mcu.cs_set(1'b1);
    `CHK(overrun, 1'b0)
    i_mcu.cs_set(1'b0);
    @(posedge clk) i2c_sel <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) test_mode <= (k == 3);
      i_mcu.start();
      i_mcu.ibyte(adr[k], 8, ack);
      `CHK(ack, ack_exp(adr[k], k == 3))
      b = rnd();
      if (ack_exp(adr[k], k == 3))
        exp.push_back(b);
      i_mcu.ibyte(b, 8, ack);
      `CHK(ack, ack_exp(adr[k], k == 3))
      i_mcu.stop();
    end
    settle("i2c");
    @(posedge clk) ram_bank <= 1'b1;
    i_mcu.start();
    i_mcu.ibyte(8'hba, 8, ack);
    b = rnd() | 8'h80;
    exp.push_back(b);
    fork
      i_mcu.ibyte(b, 8, ack);
      begin
        // Retrace inside frame sync must not let the byte through
        repeat (400) @(posedge clk);
        frame_sync <= 1'b1;
        line_sync <= 1'b1;
        repeat (30) @(posedge clk);
        line_sync <= 1'b0;
        `CHK(got.size(), 0)
        `CHK(scl_oe, 1'b1)
        repeat (10) @(posedge clk);
        frame_sync <= 1'b0;
        repeat (100) @(posedge clk);
        line_sync <= 1'b1;
        repeat (30) @(posedge clk);
        line_sync <= 1'b0;
      end
    join
    i_mcu.stop();
    `CHK(str_seen, 1'b1)
    settle("stretch");
    @(posedge clk) ram_bank <= 1'b0;
    i_mcu.start();
    i_mcu.ibyte(8'hba, 8, ack);
    i_mcu.ibyte(rnd(), 3, ack);
    i_mcu.stop();
    `CHK(err_seen, 1'b1)
    i_mcu.start();
    i_mcu.ibyte(8'hba, 8, ack);
    b = rnd();
    exp.push_back(b);
    i_mcu.ibyte(b, 8, ack);
    i_mcu.stop();
    settle("bus error");
    `CHK(scl_dat | sda_dat, 1'b0)
    conclude();
  end
endmodule
bind dscr_rx dscr_rx_assertions i_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .i2c_sel_i(i2c_sel_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .chip_sel_i(chip_sel_i), .line_sync_i(line_sync_i),
  .frame_sync_i(frame_sync_i),
  .cmd_valid_o(cmd_valid_o), .cmd_data_o(cmd_data_o), .cmd_ready_i(cmd_ready_i),
  .overrun_o(overrun_o), .bus_err_o(bus_err_o));

// [src/dscr_fifo.v]
`timescale 1ns/10ps
// Byte buffer with a registered output stage; DEPTH must be 2**AW
module dscr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output wire in_ready_o,
  output reg out_valid_o,
  output reg [WIDTH-1:0] out_data_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire wr_en;
  wire take;
  wire pop;

  // Full when the count reaches DEPTH, which sets its top bit
  assign in_ready_o = ~cnt_q[AW];
  assign wr_en = in_valid_i & ~cnt_q[AW];
  assign take = ~out_valid_o | out_ready_i;
  assign pop = take & (cnt_q != {(AW+1){1'b0}});

  // Storage has no reset; only written slots are ever read
  always @(posedge core_clk_i) begin
    if (wr_en) begin
      mem[wr_q] <= in_data_i;
    end
  end

  // Pointers, count and output stage
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end else begin
      if (wr_en) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
        out_data_o <= mem[rd_q];
      end
      if (take) begin
        out_valid_o <= pop;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// [src/dscr_map.vh]
`ifndef DSCR_MAP_VH
`define DSCR_MAP_VH
// ----------------------------------------------------------------------
// Rates and derived cycle counts
// ----------------------------------------------------------------------
`define DSCR_CLK_KHZ 100000
`define DSCR_I2C_MAX_KHZ 400
`define DSCR_TW_MAX_KHZ 1000
// Shortest half period of each serial clock, rounded down to cycles
`define DSCR_I2C_HALF_CYC (`DSCR_CLK_KHZ / (2 * `DSCR_I2C_MAX_KHZ))
`define DSCR_TW_HALF_CYC (`DSCR_CLK_KHZ / (2 * `DSCR_TW_MAX_KHZ))
// ----------------------------------------------------------------------
// Protocol fields
// ----------------------------------------------------------------------
`define DSCR_SLV_ADDR 7'h5d
`define DSCR_RAM_BIT 7
`define DSCR_BIT_LAST 3'h7
// ----------------------------------------------------------------------
// Byte buffer shape
// ----------------------------------------------------------------------
`define DSCR_FIFO_W 8
`define DSCR_FIFO_D 32
`define DSCR_FIFO_AW 5
`endif

// [src/dscr_rx.v]
`timescale 1ns/10ps
`include "dscr_map.vh"
// How it works
// RULE1: Strap low picks 3-wire, high picks I2C
// RULE2: I2C slave receiver only, up to 400 kHz
// RULE3: Address byte 1011101, read bit only in test
// RULE4: Later bytes are commands, each one acknowledged
// RULE5: STOP ends transfer; wait for start again
// RULE6: Reset or bus error drops partial byte
// RULE7: RAM byte written only in line retrace
// RULE8: RAM byte early: hold SCL low
// RULE9: Line sync active: release SCL, then write
// RULE10: 3-wire uses clock, data, high chip select
// RULE11: Chip select rise clears shift and receiver
// RULE12: Master sets each bit before rising edge
// RULE13: Rising serial clock samples data, LSB first
// RULE14: Eight bits make a byte for interpreter
// RULE15: Bytes may follow back to back
// RULE16: Chip select low aborts and disables receiver
// RULE17: Chip select tied low in I2C mode
// RULE18: Foreign address not acknowledged, skipped until STOP
// RULE19: All pins pass two-flop synchronisers first; test_mode_i and ram_bank_i feed the logic without them
module dscr_rx (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire i2c_sel_i,
  input wire test_mode_i,
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe_o,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire chip_sel_i,
  input wire line_sync_i,
  input wire frame_sync_i,
  input wire ram_bank_i,
  output wire cmd_valid_o,
  output wire [7:0] cmd_data_o,
  input wire cmd_ready_i,
  output reg overrun_o,
  output reg bus_err_o
);
  // ----------------------------------------------------------------------
  // States of the I2C receiver
  // ----------------------------------------------------------------------
  localparam [2:0] IS_IDLE = 3'h0;
  localparam [2:0] IS_SHIFT = 3'h1;
  localparam [2:0] IS_FULL = 3'h2;
  localparam [2:0] IS_HOLD = 3'h3;
  localparam [2:0] IS_ACK = 3'h4;
  localparam [2:0] IS_SKIP = 3'h5;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Bit order: {strap, frame, line, cs, sda, scl}
  reg [5:0] meta_q;
  reg [5:0] sync_q;
  reg [5:0] dly_q;
  wire [5:0] pins;
  wire scl;
  wire sda;
  wire cs;
  wire hs;
  wire vs;
  wire sel;
  wire scl_rise;
  wire scl_fall;
  wire sda_rise;
  wire sda_fall;
  wire cs_rise;
  wire start;
  wire stop;

  assign pins = {i2c_sel_i, frame_sync_i, line_sync_i, chip_sel_i, sda_i, scl_i};

  // Only the second stage and its delayed copy feed any logic
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      // Serial lines idle high; starting them high avoids a false edge
      meta_q <= 6'h03;
      sync_q <= 6'h03;
      dly_q <= 6'h03;
    end else begin
      meta_q <= pins; // [RULE19]
      sync_q <= meta_q; // [RULE19]
      dly_q <= sync_q;
    end
  end

  assign scl = sync_q[0];
  assign sda = sync_q[1];
  assign cs = sync_q[2];
  assign hs = sync_q[3];
  assign vs = sync_q[4];
  assign sel = sync_q[5];

  // Edge of a synchronised line against its delayed copy
  function edge_of;
    input cur;
    input prev;
    input rising;
    begin
      edge_of = rising ? (cur & ~prev) : (~cur & prev);
    end
  endfunction

  // Edge detection at 100 MHz; both serial clocks are far slower
  assign scl_rise = edge_of(scl, dly_q[0], 1'b1);
  assign scl_fall = edge_of(scl, dly_q[0], 1'b0);
  assign sda_rise = edge_of(sda, dly_q[1], 1'b1);
  assign sda_fall = edge_of(sda, dly_q[1], 1'b0);
  assign cs_rise = edge_of(cs, dly_q[2], 1'b1);
  assign start = sda_fall & scl & dly_q[0];
  assign stop = sda_rise & scl & dly_q[0];

  // ----------------------------------------------------------------------
  // Shared byte buffer
  // ----------------------------------------------------------------------
  wire fifo_rdy;
  wire push_v;
  wire [7:0] push_d;

  dscr_fifo #(
    .WIDTH(`DSCR_FIFO_W),
    .DEPTH(`DSCR_FIFO_D),
    .AW(`DSCR_FIFO_AW)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push_v),
    .in_data_i(push_d),
    .in_ready_o(fifo_rdy),
    .out_valid_o(cmd_valid_o),
    .out_data_o(cmd_data_o),
    .out_ready_i(cmd_ready_i)
  );

  // ----------------------------------------------------------------------
  // I2C slave receiver
  // ----------------------------------------------------------------------
  reg [2:0] i2c_st_q;
  reg [2:0] i2c_cnt_q;
  reg [7:0] i2c_sh_q;
  reg addr_ph_q;
  wire addr_ok;
  wire ram_byte;
  wire hold_ok;
  wire i2c_go;
  wire i2c_push;
  wire mid_byte;

  // Write bit must be 0 unless test mode lets a read bit through
  assign addr_ok = (i2c_sh_q[7:1] == `DSCR_SLV_ADDR) &
                   (~i2c_sh_q[0] | test_mode_i); // [RULE3]
  assign ram_byte = ram_bank_i & i2c_sh_q[`DSCR_RAM_BIT];
  // RAM bytes wait for line retrace outside frame sync
  assign hold_ok = ~ram_byte | (hs & ~vs); // [RULE7]
  assign i2c_go = hold_ok & fifo_rdy;
  assign i2c_push = sel & ~start & ~stop & ~addr_ph_q & i2c_go &
                    (((i2c_st_q == IS_FULL) & scl_fall) | (i2c_st_q == IS_HOLD));
  // A start or stop is legal only on a byte boundary
  assign mid_byte = ((i2c_st_q == IS_SHIFT) & (i2c_cnt_q != 3'h0)) |
                    (i2c_st_q == IS_FULL) | (i2c_st_q == IS_ACK);

  // Receiver state; the strap keeps it idle in 3-wire mode
  always @(posedge core_clk_i) begin
    if (!rst_n_i || !sel) begin
      i2c_st_q <= IS_IDLE; // [RULE1] [RULE6]
      i2c_cnt_q <= 3'h0;
      i2c_sh_q <= 8'h00;
      addr_ph_q <= 1'b1;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      bus_err_o <= 1'b0;
    end else if (stop | start) begin
      // Misplaced conditions are bus errors: drop byte, wait for start
      bus_err_o <= mid_byte;
      i2c_st_q <= (start & ~mid_byte) ? IS_SHIFT : IS_IDLE; // [RULE5] [RULE6]
      i2c_cnt_q <= 3'h0;
      i2c_sh_q <= 8'h00; // [RULE6]
      addr_ph_q <= 1'b1;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      bus_err_o <= 1'b0;
      case (i2c_st_q)
        IS_SHIFT: begin
          // MSB first on each rising SCL
          if (scl_rise) begin
            i2c_sh_q <= {i2c_sh_q[6:0], sda};
            i2c_cnt_q <= i2c_cnt_q + 3'h1;
            if (i2c_cnt_q == `DSCR_BIT_LAST) begin
              i2c_st_q <= IS_FULL;
            end
          end
        end
        IS_FULL: begin
          if (scl_fall) begin
            if (addr_ph_q) begin
              sda_oe_o <= addr_ok; // [RULE18]
              i2c_st_q <= addr_ok ? IS_ACK : IS_SKIP; // [RULE18]
            end else if (i2c_go) begin
              sda_oe_o <= 1'b1; // [RULE4]
              i2c_st_q <= IS_ACK;
            end else begin
              // Stretch the clock until the byte can be stored
              scl_oe_o <= 1'b1; // [RULE8]
              sda_oe_o <= 1'b1;
              i2c_st_q <= IS_HOLD;
            end
          end
        end
        IS_HOLD: begin
          if (i2c_go) begin
            scl_oe_o <= 1'b0; // [RULE9]
            i2c_st_q <= IS_ACK;
          end
        end
        IS_ACK: begin
          // Acknowledge stands for one SCL low-high-low period
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            addr_ph_q <= 1'b0; // [RULE4]
            i2c_cnt_q <= 3'h0;
            i2c_st_q <= IS_SHIFT;
          end
        end
        IS_SKIP: begin
          sda_oe_o <= 1'b0;
        end
        IS_IDLE: begin
          sda_oe_o <= 1'b0;
        end
        default: begin
          i2c_st_q <= IS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Three-wire receiver
  // ----------------------------------------------------------------------
  reg tw_on_q;
  reg [2:0] tw_cnt_q;
  reg [7:0] tw_sh_q;
  wire tw_bit;
  wire tw_push;

  // A sample only counts while enabled, selected and chip select high
  assign tw_bit = ~sel & tw_on_q & cs & scl_rise; // [RULE10] [RULE13]
  assign tw_push = tw_bit & (tw_cnt_q == `DSCR_BIT_LAST); // [RULE14]

  always @(posedge core_clk_i) begin
    if (!rst_n_i || sel) begin
      tw_on_q <= 1'b0; // [RULE1]
      tw_cnt_q <= 3'h0;
      tw_sh_q <= 8'h00;
    end else if (cs_rise) begin
      tw_on_q <= 1'b1; // [RULE11]
      tw_cnt_q <= 3'h0;
      tw_sh_q <= 8'h00; // [RULE11]
    end else if (!cs) begin
      tw_on_q <= 1'b0; // [RULE16]
      tw_cnt_q <= 3'h0; // [RULE16]
    end else if (tw_bit) begin
      // LSB first; counter wraps so the next byte follows at once
      tw_sh_q <= {sda, tw_sh_q[7:1]}; // [RULE13]
      tw_cnt_q <= tw_cnt_q + 3'h1; // [RULE15]
    end
  end

  // ----------------------------------------------------------------------
  // Byte hand-off and pin drivers
  // ----------------------------------------------------------------------
  // The receivers are exclusive, so a simple OR-style select suffices
  assign push_v = i2c_push | (tw_push & fifo_rdy);
  assign push_d = sel ? i2c_sh_q : {sda, tw_sh_q[7:1]}; // [RULE14]

  // The 3-wire master cannot be stalled; a full buffer loses the byte
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      overrun_o <= 1'b0;
    end else if (tw_push & ~fifo_rdy) begin
      overrun_o <= 1'b1;
    end else if (cs_rise) begin
      overrun_o <= 1'b0;
    end
  end

  // Open-drain lines only ever pull low; never drive data out
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0; // [RULE2]
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end
endmodule
